/* verilog/ipomx_pkg.sv */
// constants for the indicator pin output multiplexer
package ipomx_pkg;

    // register indices and their byte addresses on the bus
    localparam logic [15:0] IND_CFG_IDX = 16'h0452;
    localparam logic [15:0] CLK_CFG_IDX = 16'h0453;
    localparam logic [15:0] IND_CFG_ADDR = 16'(IND_CFG_IDX * 4);
    localparam logic [15:0] CLK_CFG_ADDR = 16'(CLK_CFG_IDX * 4);

    // indicator config field positions, pin 1 in the upper byte
    localparam int PIN1_DIV_BIT = 15;
    localparam int PIN1_SRC_LSB = 12;
    localparam int PIN1_INV_BIT = 11;
    localparam int PIN1_SEL_LSB = 8;
    localparam int PIN0_DIV_BIT = 7;
    localparam int PIN0_SRC_LSB = 4;
    localparam int PIN0_INV_BIT = 3;
    localparam int PIN0_SEL_LSB = 0;

    // clock pin config: writable bits and the gpio control field
    localparam logic [15:0] CLK_CFG_WMASK = 16'h81ff;
    localparam int CLK_SEL_LSB = 0;

    // reset values
    localparam logic [15:0] IND_CFG_RST = 16'h0000;
    localparam logic [15:0] CLK_CFG_RST = 16'h0001;
    localparam logic [2:0] SEL_STRAP_HI = 3'h1;
    localparam logic [2:0] SEL_STRAP_LO = 3'h0;
    localparam logic [2:0] CLK_SEL_STRAP_HI = 3'h0;
    localparam logic [2:0] CLK_SEL_STRAP_LO = 3'h1;

    // cycles after reset release before the strap is taken
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // output select codes
    localparam logic [2:0] OUT_LINK = 3'h0;
    localparam logic [2:0] OUT_CLOCK = 3'h1;
    localparam logic [2:0] OUT_WAKE = 3'h2;
    localparam logic [2:0] OUT_UNDER_VOLT = 3'h3;
    localparam logic [2:0] OUT_TS_TX = 3'h4;
    localparam logic [2:0] OUT_TS_RX = 3'h5;
    localparam logic [2:0] OUT_DISCHARGE = 3'h6;
    localparam logic [2:0] OUT_IRQ = 3'h7;

    // clock source select codes
    localparam logic [2:0] SRC_CRYSTAL = 3'h0;
    localparam logic [2:0] SRC_PLL_200 = 3'h1;
    localparam logic [2:0] SRC_ADC_67 = 3'h2;
    localparam logic [2:0] SRC_FREE_200 = 3'h3;
    localparam logic [2:0] SRC_MII_25 = 3'h4;
    localparam logic [2:0] SRC_REF_25 = 3'h5;
    localparam logic [2:0] SRC_CORE_100 = 3'h6;
    localparam logic [2:0] SRC_DSP_67 = 3'h7;

    // number of clock sources each pin may pick
    localparam int PIN0_SRC_COUNT = 8;
    localparam int PIN1_SRC_COUNT = 6;

    // bus transfer phase
    typedef enum logic [1:0] {IPOMX_IDLE, IPOMX_SETUP, IPOMX_ACCESS}
        ipomx_phase_t;

endpackage

/* verilog/ipomx_pin_if.sv */
// configuration and result of one indicator pin
`timescale 1ns/1ps
interface ipomx_pin_if;
    logic [2:0] sel;
    logic [2:0] src_sel;
    logic div_en;
    logic inv_en;
    logic [7:0] evt;
    logic [7:0] clk_src;
    logic pin_out;

    modport ctrl (output sel, output src_sel, output div_en,
                  output inv_en, output evt, output clk_src,
                  input pin_out);
    modport pin (input sel, input src_sel, input div_en,
                 input inv_en, input evt, input clk_src,
                 output pin_out);
endinterface

/* verilog/ipomx_pin.sv */
// one indicator pin: clock conditioning and output select
`timescale 1ns/1ps
module ipomx_pin #(
    parameter int SRC_COUNT = 8
) (
    input wire logic clk_i,           // system clock
    input wire logic rst_i,           // async reset, active high
    ipomx_pin_if.pin cfg              // config in, pin level out
);

    // a pin never has more than eight sources; refused at elaboration
    if (SRC_COUNT < 1 || SRC_COUNT > 8)
    begin
        $error("ipomx_pin: SRC_COUNT out of range");
    end

    logic src_level;
    logic src_prev;
    logic half;
    logic clk_out;
    logic next_out;

    // source pick; codes past the pin's list give a quiet low
    always_comb
    begin
        if (32'(cfg.src_sel) < SRC_COUNT)
            src_level = cfg.clk_src[cfg.src_sel];
        else
            src_level = 1'b0;
    end

    // halver toggles on each rising edge of the picked source
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            src_prev <= 1'b0;
            half <= 1'b0;
        end
        else
        begin
            src_prev <= src_level;
            if (src_level && !src_prev)
                half <= ~half;
        end
    end

    // divide then invert, only on the clock route
    always_comb
    begin
        clk_out = cfg.div_en ? half : src_level;
        clk_out = clk_out ^ cfg.inv_en;
    end

    // code one carries the clock, the rest pick an event
    always_comb
    begin
        if (cfg.sel == ipomx_pkg::OUT_CLOCK)
            next_out = clk_out;
        else
            next_out = cfg.evt[cfg.sel];
    end

    // registered so the pad sees no select glitches
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            cfg.pin_out <= 1'b0;
        else
            cfg.pin_out <= next_out;
    end

endmodule

/* verilog/ipomx_top.sv */
// indicator pin output multiplexer with its APB register slave
//
// Summary of operation
// - pin 1 clock halved when bit 15 set
// - pin 1 source codes 000b to 101b
// - pin 1 clock inverted when bit 11 set
// - pin 1 select picks one of eight outputs
// - pin 1 select resets from receive-data-3 strap
// - pin 0 clock halved when bit 7 set
// - pin 0 adds core and DSP clocks
// - pin 0 clock inverted when bit 3 set
// - pin 0 select picks one of eight outputs
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module ipomx_top (
    input wire logic CLK_I,                // 10 MHz system clock
    input wire logic RST_I,                // async reset, active high
    input wire logic PSEL_I,               // apb select
    input wire logic PENABLE_I,            // apb access phase
    input wire logic PWRITE_I,             // apb write when high
    input wire logic [15:0] PADDR_I,       // apb byte address
    input wire logic [31:0] PWDATA_I,      // apb write data
    output logic [31:0] PRDATA_O,          // apb read data
    output logic PREADY_O,                 // apb ready
    output logic PSLVERR_O,                // apb error, unmapped
    input wire logic RECEIVE_DATA3_STRAP_I, // strap pin level
    input wire logic LINK_I,               // link indication
    input wire logic LINK_ACT_I,           // link plus activity
    input wire logic WAKE_ON_LAN_IND_I,    // wake-on-lan event
    input wire logic UNDER_VOLT_I,         // under-voltage flag
    input wire logic TS_TX_I,              // timestamp transmit
    input wire logic TS_RX_I,              // timestamp receive
    input wire logic DISCHARGE_I,          // discharge detected
    input wire logic INTERRUPT_I,          // device interrupt
    input wire logic [7:0] CLK_SRC_I,      // internal clock levels
    output logic INDICATOR0_O,             // first indicator pin
    output logic INDICATOR1_O,             // second indicator pin
    output logic [2:0] CLK_PIN_SEL_O       // clock pin select field
);

    logic [15:0] ind_cfg;
    logic [15:0] clk_cfg;
    logic strap_meta;
    logic strap_sync;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic cfg_live;
    ipomx_pkg::ipomx_phase_t phase;
    logic hit_ind;
    logic hit_clk;
    logic mapped;
    logic setup;
    logic wr_take;
    logic [15:0] next_rdata;
    logic [7:0] evt_pin0;
    logic [7:0] evt_pin1;

    ipomx_pin_if pin0_if ();
    ipomx_pin_if pin1_if ();

    // strap pin is asynchronous, two flops before any use
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            strap_meta <= 1'b0;
            strap_sync <= 1'b0;
        end
        else
        begin
            strap_meta <= RECEIVE_DATA3_STRAP_I;
            strap_sync <= strap_meta;
        end
    end

    // wait for the synchroniser to fill before taking the strap
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
        end
        else if (!strap_done)
        begin
            if (strap_cnt == ipomx_pkg::STRAP_SETTLE)
                strap_done <= 1'b1;
            else
                strap_cnt <= strap_cnt + 2'h1;
        end
    end

    // one edge past the strap load, so read data is reloaded first
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            cfg_live <= 1'b0;
        else
            cfg_live <= strap_done;
    end

    // address decode on the registered index layout
    always_comb
    begin
        hit_ind = 1'b0;
        hit_clk = 1'b0;
        if (PADDR_I == ipomx_pkg::IND_CFG_ADDR)
            hit_ind = 1'b1;
        else if (PADDR_I == ipomx_pkg::CLK_CFG_ADDR)
            hit_clk = 1'b1;
    end

    assign mapped = hit_ind | hit_clk;
    assign setup = PSEL_I & ~PENABLE_I;

    // bus stalls until the strap is in, so software cannot race it
    assign PREADY_O = PSEL_I & PENABLE_I & cfg_live;
    assign PSLVERR_O = PREADY_O & ~mapped;
    assign wr_take = PREADY_O & PWRITE_I & mapped;

    // phase tracker, kept for visibility of the transfer state
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            phase <= ipomx_pkg::IPOMX_IDLE;
        else
        begin
            case (phase)
                ipomx_pkg::IPOMX_IDLE:
                    if (setup)
                        phase <= ipomx_pkg::IPOMX_SETUP;
                ipomx_pkg::IPOMX_SETUP:
                    phase <= ipomx_pkg::IPOMX_ACCESS;
                ipomx_pkg::IPOMX_ACCESS:
                    if (PREADY_O)
                        phase <= setup ? ipomx_pkg::IPOMX_SETUP
                                       : ipomx_pkg::IPOMX_IDLE;
                default:
                    phase <= ipomx_pkg::IPOMX_IDLE;
            endcase
        end
    end

    // indicator config; pin 1 select reset comes from the strap
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            ind_cfg <= ipomx_pkg::IND_CFG_RST;
        else if (!strap_done && strap_cnt == ipomx_pkg::STRAP_SETTLE)
            ind_cfg[ipomx_pkg::PIN1_SEL_LSB +: 3] <=
                strap_sync ? ipomx_pkg::SEL_STRAP_HI
                           : ipomx_pkg::SEL_STRAP_LO;
        else if (wr_take && hit_ind)
            ind_cfg <= PWDATA_I[15:0];
    end

    // clock pin config; kept for software, strap sets its select
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            clk_cfg <= ipomx_pkg::CLK_CFG_RST;
        else if (!strap_done && strap_cnt == ipomx_pkg::STRAP_SETTLE)
            clk_cfg[ipomx_pkg::CLK_SEL_LSB +: 3] <=
                strap_sync ? ipomx_pkg::CLK_SEL_STRAP_HI
                           : ipomx_pkg::CLK_SEL_STRAP_LO;
        else if (wr_take && hit_clk)
            clk_cfg <= PWDATA_I[15:0] & ipomx_pkg::CLK_CFG_WMASK;
    end

    assign CLK_PIN_SEL_O = clk_cfg[ipomx_pkg::CLK_SEL_LSB +: 3];

    // read data follows the register until ready, then stands
    always_comb
    begin
        next_rdata = 16'h0000;
        if (hit_ind)
            next_rdata = ind_cfg;
        else if (hit_clk)
            next_rdata = clk_cfg;
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            PRDATA_O <= 32'h0000_0000;
        else if (PSEL_I && !PREADY_O)
            PRDATA_O <= {16'h0000, next_rdata}; // wait states refresh it
    end

    // event vectors by select code; slot one is the clock route
    always_comb
    begin
        evt_pin0 = {INTERRUPT_I, DISCHARGE_I, TS_RX_I, TS_TX_I,
                    UNDER_VOLT_I, WAKE_ON_LAN_IND_I, 1'b0, LINK_I};
        evt_pin1 = {INTERRUPT_I, DISCHARGE_I, TS_RX_I, TS_TX_I,
                    UNDER_VOLT_I, WAKE_ON_LAN_IND_I, 1'b0, LINK_ACT_I};
    end

    // first pin fields
    assign pin0_if.sel = ind_cfg[ipomx_pkg::PIN0_SEL_LSB +: 3];
    assign pin0_if.src_sel = ind_cfg[ipomx_pkg::PIN0_SRC_LSB +: 3];
    assign pin0_if.div_en = ind_cfg[ipomx_pkg::PIN0_DIV_BIT];
    assign pin0_if.inv_en = ind_cfg[ipomx_pkg::PIN0_INV_BIT];
    assign pin0_if.evt = evt_pin0;
    assign pin0_if.clk_src = CLK_SRC_I;

    // second pin fields
    assign pin1_if.sel = ind_cfg[ipomx_pkg::PIN1_SEL_LSB +: 3];
    assign pin1_if.src_sel = ind_cfg[ipomx_pkg::PIN1_SRC_LSB +: 3];
    assign pin1_if.div_en = ind_cfg[ipomx_pkg::PIN1_DIV_BIT];
    assign pin1_if.inv_en = ind_cfg[ipomx_pkg::PIN1_INV_BIT];
    assign pin1_if.evt = evt_pin1;
    assign pin1_if.clk_src = CLK_SRC_I;

    // first pin may pick all eight sources
    ipomx_pin #(
        .SRC_COUNT(ipomx_pkg::PIN0_SRC_COUNT)
    ) u_pin0 (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .cfg(pin0_if.pin)
    );

    // second pin stops at the reference clock, code 101b
    ipomx_pin #(
        .SRC_COUNT(ipomx_pkg::PIN1_SRC_COUNT)
    ) u_pin1 (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .cfg(pin1_if.pin)
    );

    assign INDICATOR0_O = pin0_if.pin_out;
    assign INDICATOR1_O = pin1_if.pin_out;

endmodule

/* dv/ipomx_checker.sv */
// port assertions for the indicator mux
`timescale 1ns/1ps
module ipomx_checker (
    input wire logic CLK_I, // clock
    input wire logic RST_I, // reset
    input wire logic PSEL_I, // apb
    input wire logic PENABLE_I, // apb
    input wire logic PWRITE_I, // apb
    input wire logic [15:0] PADDR_I, // apb
    input wire logic [31:0] PWDATA_I, // apb
    input wire logic [31:0] PRDATA_O, // apb
    input wire logic PREADY_O, // apb
    input wire logic PSLVERR_O, // apb
    input wire logic LINK_I, // event
    input wire logic LINK_ACT_I, // event
    input wire logic WAKE_ON_LAN_IND_I, // event
    input wire logic UNDER_VOLT_I, // event
    input wire logic TS_TX_I, // event
    input wire logic TS_RX_I, // event
    input wire logic DISCHARGE_I, // event
    input wire logic INTERRUPT_I, // event
    input wire logic INDICATOR0_O, // pin
    input wire logic INDICATOR1_O // pin
);
    logic [15:0] sh;
    logic sh_v;
    logic [7:0] ev0;
    logic [7:0] ev1;
    logic exp0;
    logic exp1;
    logic hit;
    // events by select code; clock code is left to the bench
    assign ev0 = {INTERRUPT_I, DISCHARGE_I, TS_RX_I, TS_TX_I, UNDER_VOLT_I,
        WAKE_ON_LAN_IND_I, 1'b0, LINK_I};
    assign ev1 = {ev0[7:2], 1'b0, LINK_ACT_I};
    assign exp0 = ev0[sh[2:0]];
    assign exp1 = ev1[sh[10:8]];
    assign hit = PADDR_I == ipomx_pkg::IND_CFG_ADDR ||
        PADDR_I == ipomx_pkg::CLK_CFG_ADDR;
    // config shadow; reset value hangs on the strap, so wait for a write
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            sh_v <= 1'b0;
            sh <= 16'h0000;
        end
        else if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I &&
                 PADDR_I == ipomx_pkg::IND_CFG_ADDR)
        begin
            sh_v <= 1'b1;
            sh <= PWDATA_I[15:0];
        end
    end
    default clocking @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);
    property p_ready_in_access;
        PREADY_O |-> PSEL_I && PENABLE_I;
    endproperty
    a_ready_in_access: assert property (p_ready_in_access)
        else $error("ready outside access");
    property p_ready_wait;
        $rose(PENABLE_I) |-> ##[0:4] PREADY_O;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("ready too late");
    property p_strap_wait;
        $fell(RST_I) |-> !PREADY_O [*3];
    endproperty
    a_strap_wait: assert property (p_strap_wait)
        else $error("ready before strap load");
    property p_err_map;
        PREADY_O |-> PSLVERR_O == !hit;
    endproperty
    a_err_map: assert property (p_err_map)
        else $error("error flag wrong");
    property p_upper_zero;
        PREADY_O && !PWRITE_I |-> PRDATA_O[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read bits set");
    property p_bad_read;
        PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0000_0000;
    endproperty
    a_bad_read: assert property (p_bad_read)
        else $error("unmapped read not zero");
    property p_pin0_event;
        sh_v && sh[2:0] != 3'h1 |=> INDICATOR0_O == $past(exp0);
    endproperty
    a_pin0_event: assert property (p_pin0_event)
        else $error("pin 0 route wrong");
    property p_pin1_event;
        sh_v && sh[10:8] != 3'h1 |=> INDICATOR1_O == $past(exp1);
    endproperty
    a_pin1_event: assert property (p_pin1_event)
        else $error("pin 1 route wrong");
endmodule

bind ipomx_top ipomx_checker u_checker (.*);

/* dv/tb_indicator_pin_output_mux.sv */
// self-checking bench for the indicator mux
`timescale 1ns/1ps
module tb_indicator_pin_output_mux;
    logic clk, rst, psel, pen, pwr, pready, pslverr, strap, e, last;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] ev, src;
    logic [1:0] ind;
    logic [2:0] csel;
    int num_errors, cmp_count, k;
    ipomx_top dut (
        .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .RECEIVE_DATA3_STRAP_I(strap), .LINK_I(ev[0]), .LINK_ACT_I(ev[1]),
        .WAKE_ON_LAN_IND_I(ev[2]), .UNDER_VOLT_I(ev[3]), .TS_TX_I(ev[4]),
        .TS_RX_I(ev[5]), .DISCHARGE_I(ev[6]), .INTERRUPT_I(ev[7]),
        .CLK_SRC_I(src), .INDICATOR0_O(ind[0]), .INDICATOR1_O(ind[1]),
        .CLK_PIN_SEL_O(csel)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // one apb transfer; a gap edge keeps psel from two drives per step
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        // hold the request until ready is seen at a rising edge
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (pready !== 1'b1)
        begin
            num_errors++;
            wrap_up();
        end
    endtask
    task automatic do_reset(input logic s);
        @(posedge clk);
        strap <= s;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask
    // let the registered pin settle; sample at an edge so the next
    // stimulus is still driven just after a rising edge
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        {rst, psel, pen, pwr, strap} = 5'h13;
        {paddr, pwdata, ev, src} = '0;
        num_errors = 0;
        cmp_count = 0;
        for (int s = 1; s >= 0; s--)
        begin
            do_reset(s[0]);
            apb(1'b0, ipomx_pkg::IND_CFG_ADDR, 32'h0);
            check(q, s ? 32'h0000_0100 : 32'h0);
            apb(1'b0, ipomx_pkg::CLK_CFG_ADDR, 32'h0);
            check(q, s ? 32'h0 : 32'h0000_0001);
            check({29'h0, csel}, s ? 32'h0 : 32'h1);
        end
        apb(1'b1, ipomx_pkg::IND_CFG_ADDR, 32'h0000_ffff);
        apb(1'b0, ipomx_pkg::IND_CFG_ADDR, 32'h0);
        check(q, 32'h0000_ffff);
        apb(1'b1, ipomx_pkg::CLK_CFG_ADDR, 32'h0000_ffff);
        apb(1'b0, ipomx_pkg::CLK_CFG_ADDR, 32'h0);
        check(q, 32'h0000_81ff);
        check({29'h0, csel}, 32'h7);
        apb(1'b0, 16'h0010, 32'h0);
        check({q[30:0], e}, 32'h1);
        // every event route, driven low then high with the rest inverted
        for (int p = 0; p < 2; p++)
            for (int c = 0; c < 8; c++)
                if (c != 1)
                begin
                    apb(1'b1, ipomx_pkg::IND_CFG_ADDR, 32'(c) << (8 * p));
                    for (int v = 0; v < 2; v++)
                    begin
                        k = (c == 0) ? p : c;
                        ev <= v ? 8'h1 << k : ~(8'h1 << k);
                        settle();
                        check({31'h0, ind[p]}, 32'(v));
                    end
                end
        // clock route: each source held steady, with and without invert
        for (int p = 0; p < 2; p++)
            for (int s = 0; s < 8; s++)
                for (int i = 0; i < 2; i++)
                begin
                    apb(1'b1, ipomx_pkg::IND_CFG_ADDR,
                        32'({s[2:0], i[0], 3'h1}) << (8 * p));
                    for (int v = 0; v < 2; v++)
                    begin
                        src <= v ? 8'h1 << s : ~(8'h1 << s);
                        settle();
                        check({31'h0, ind[p]},
                            32'((v && !(p && s > 5)) ^ i));
                    end
                end
        // halver: count pin edges while source toggles every cycle
        for (int p = 0; p < 2; p++)
            for (int d = 0; d < 2; d++)
            begin
                apb(1'b1, ipomx_pkg::IND_CFG_ADDR,
                    32'({d[0], 4'h0, 3'h1}) << (8 * p));
                k = 0;
                for (int i = 0; i < 20; i++)
                begin
                    @(posedge clk);
                    src <= ~src;
                    @(negedge clk);
                    if (i > 3 && ind[p] !== last)
                        k++;
                    last = ind[p];
                end
                check(32'(k), d ? 32'd8 : 32'd16);
            end
        wrap_up();
    end
endmodule
